/* File: design/ascf_params.svh */
// register offsets, field positions and timing counts of the serial port
`ifndef ASCF_PARAMS_SVH
`define ASCF_PARAMS_SVH
`define ASCF_ADDR_STATUS 3'h0
`define ASCF_ADDR_CTRL2 3'h1
`define ASCF_ADDR_DATA 3'h2
`define ASCF_ADDR_CTRL1 3'h3
`define ASCF_ADDR_IRQ_STAT 3'h4
`define ASCF_ADDR_IRQ_MASK 3'h5
`define ASCF_C2_TIE 7
`define ASCF_C2_TX_COMPLETE_IRQ_ENABLE 6
`define ASCF_C2_RIE 5
`define ASCF_C2_TE 3
`define ASCF_C2_RE 2
`define ASCF_C2_RWU 1
`define ASCF_C2_SBK 0
`define ASCF_C1_LOOP 0
`define ASCF_C1_WAKE 1
`define ASCF_C1_LONG_BREAK_SELECT 2
`define ASCF_C1_NINE 3
`define ASCF_S1_TX_BUFFER_EMPTY 7
`define ASCF_S1_TC 6
`define ASCF_S1_RX_BUFFER_FULL 5
`define ASCF_BAUD_DIV 16'h01b2
`define ASCF_C2_RESET 8'h00
`define ASCF_C1_RESET 8'h00
`endif

/* File: design/ascf_pkg.sv */
// state types of the serial port transmitter and receiver
package ascf_pkg;
    typedef enum logic [1:0] {ASCF_TX_IDLE, ASCF_TX_DATA, ASCF_TX_BREAK,
        ASCF_TX_PREAMBLE} ascf_tx_state_t;
    typedef enum logic [1:0] {ASCF_RX_IDLE, ASCF_RX_SHIFT,
        ASCF_RX_DONE} ascf_rx_state_t;
endpackage : ascf_pkg

/* File: design/ascf_link_if.sv */
// serial line pair between the port and the remote node
`timescale 1ns/1ns
interface ascf_link_if;
    logic port_txd;
    logic node_txd;
    modport port_end (output port_txd, input node_txd);
    modport node_end (input port_txd, output node_txd);
endinterface : ascf_link_if

/* File: design/ascf_port.sv */
// serial port control, status flags, transmitter and receiver
// Operation
// - receiver_on enables receiver, else pin released
// - loop_mode releases receive pin regardless
// - standby request holds receiver awaiting wakeup
// - wakeup by idle line, or by address bit (stop bit in nine mode)
// - hardware clears standby request on wakeup
// - break_queue one then zero sends break
// - break repeats while set, 10/11/13/14 bits
// - a second break may slip in
// - status register read only, writes ignored
// - tx empty set at reset and on load
// - tx empty cleared by status read, data write
// - tx complete set when transmitter idle
// - tx complete cleared by read then action
// - rx full set on character arrival
// - rx full cleared by status read, data read
// - per-flag enables request interrupt
// - transmitter off then on queues preamble
`timescale 1ns/1ns
`include "ascf_params.svh"
module ascf_port #(
    parameter logic [15:0] BAUD_DIV = `ASCF_BAUD_DIV
) (
    // system
    input wire logic CLK_SYS,
    input wire logic RST,
    // register port
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic IRQ,
    // receive pin handed to general port use
    output logic RX_PIN_RELEASED,
    // link
    ascf_link_if.port_end link
);
    // ****************************************
    // registers
    // ****************************************
    logic [7:0] ctrl2;
    logic [7:0] ctrl1;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic tx_buffer_empty, tc, rx_buffer_full;
    logic arm_tx_buffer_empty, arm_tc, arm_rx_buffer_full;
    logic [2:0] ev_stat, ev_mask;
    logic brk_pending, pre_pending;
    logic [15:0] baud_cnt;
    logic tick;
    logic rx_s1, rx_s2;
    ascf_pkg::ascf_tx_state_t tx_state;
    ascf_pkg::ascf_rx_state_t rx_state;
    logic [8:0] tx_sh;
    logic [3:0] tx_bits;
    logic [3:0] tx_len;
    logic txd;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    logic [3:0] idle_cnt;
    logic rx_prev;

    wire wr_stat = WR && ADDR == `ASCF_ADDR_STATUS;
    wire rd_stat = RD && ADDR == `ASCF_ADDR_STATUS;
    wire wr_c2 = WR && ADDR == `ASCF_ADDR_CTRL2;
    wire wr_data = WR && ADDR == `ASCF_ADDR_DATA;
    wire rd_data = RD && ADDR == `ASCF_ADDR_DATA;
    wire wr_c1 = WR && ADDR == `ASCF_ADDR_CTRL1;
    wire wr_istat = WR && ADDR == `ASCF_ADDR_IRQ_STAT;
    wire wr_imask = WR && ADDR == `ASCF_ADDR_IRQ_MASK;
    wire te = ctrl2[`ASCF_C2_TE];
    wire re = ctrl2[`ASCF_C2_RE];
    wire receiver_standby_request = ctrl2[`ASCF_C2_RWU];
    wire break_queue = ctrl2[`ASCF_C2_SBK];
    wire loop_mode = ctrl1[`ASCF_C1_LOOP];
    wire nine = ctrl1[`ASCF_C1_NINE];
    wire rx_active = re && !loop_mode;
    wire sbk_rise = wr_c2 && WDATA[`ASCF_C2_SBK] && !break_queue;
    wire sbk_fall = wr_c2 && !WDATA[`ASCF_C2_SBK] && break_queue;
    wire te_rise = wr_c2 && WDATA[`ASCF_C2_TE] && !te;
    wire tx_idle = tx_state == ascf_pkg::ASCF_TX_IDLE;
    wire tx_load = tick && tx_idle && te && !tx_buffer_empty && !brk_pending
        && !pre_pending;
    wire tx_fin = tick && !tx_idle && tx_bits == tx_len;
    wire rx_bit = loop_mode ? txd : rx_s2;
    wire [3:0] char_len = nine ? 4'd11 : 4'd10;
    wire [3:0] brk_len = ctrl1[`ASCF_C1_LONG_BREAK_SELECT] ? (nine ? 4'd14 : 4'd13)
        : (nine ? 4'd11 : 4'd10);
    // one sample per bit tick, late in the bit after the synchroniser
    wire rx_sample = tick;
    wire rx_done = rx_state == ascf_pkg::ASCF_RX_DONE;
    wire rx_msb = nine ? rx_sh[8] : rx_sh[7];
    wire wake_idle = receiver_standby_request && !ctrl1[`ASCF_C1_WAKE] && rx_state ==
        ascf_pkg::ASCF_RX_IDLE && idle_cnt == char_len && tick;
    wire wake_mark = receiver_standby_request && ctrl1[`ASCF_C1_WAKE] && rx_done && rx_msb;
    wire rx_store = rx_done && (!receiver_standby_request || wake_mark);
    wire [2:0] events = {rx_store, tx_fin && tx_state ==
        ascf_pkg::ASCF_TX_DATA, tx_load};
    wire [7:0] status = {tx_buffer_empty, tc, rx_buffer_full, 5'h00};
    wire [7:0] next_rdata = ADDR == `ASCF_ADDR_STATUS ? status :
        ADDR == `ASCF_ADDR_CTRL2 ? ctrl2 : ADDR == `ASCF_ADDR_DATA ? rx_buf
        : ADDR == `ASCF_ADDR_CTRL1 ? ctrl1 : ADDR == `ASCF_ADDR_IRQ_STAT ?
        {5'h00, ev_stat} : ADDR == `ASCF_ADDR_IRQ_MASK ? {5'h00, ev_mask}
        : 8'h00;
    wire flag_irq = (tx_buffer_empty && ctrl2[`ASCF_C2_TIE]) || (tc &&
        ctrl2[`ASCF_C2_TX_COMPLETE_IRQ_ENABLE]) || (rx_buffer_full && ctrl2[`ASCF_C2_RIE]);
    wire next_irq = flag_irq || |(ev_stat & ev_mask);

    // ****************************************
    // bus and control
    // ****************************************
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctrl2 <= `ASCF_C2_RESET;
            ctrl1 <= `ASCF_C1_RESET;
            tx_buf <= 8'h00;
            RDATA <= 8'h00;
            IRQ <= 1'b0;
            ev_stat <= 3'h0;
            ev_mask <= 3'h0;
            RX_PIN_RELEASED <= 1'b1;
        end else begin
            if (wr_c2) ctrl2 <= WDATA;
            if (wake_idle || wake_mark) ctrl2[`ASCF_C2_RWU] <= 1'b0;
            if (wr_c1) ctrl1 <= WDATA;
            if (wr_data) tx_buf <= WDATA;
            if (wr_imask) ev_mask <= WDATA[2:0];
            ev_stat <= (ev_stat & ~(wr_istat ? WDATA[2:0] : 3'h0)) | events;
            RDATA <= RD ? next_rdata : 8'h00;
            IRQ <= next_irq;
            RX_PIN_RELEASED <= !rx_active;
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            tx_buffer_empty <= 1'b1;
            tc <= 1'b1;
            rx_buffer_full <= 1'b0;
            arm_tx_buffer_empty <= 1'b0;
            arm_tc <= 1'b0;
            arm_rx_buffer_full <= 1'b0;
            brk_pending <= 1'b0;
            pre_pending <= 1'b0;
        end else begin
            // status writes fall through: no flag reacts
            if (rd_stat) begin
                arm_tx_buffer_empty <= tx_buffer_empty;
                arm_tc <= tc;
                arm_rx_buffer_full <= rx_buffer_full;
            end
            if (tx_load) tx_buffer_empty <= 1'b1;
            else if (wr_data && arm_tx_buffer_empty) tx_buffer_empty <= 1'b0;
            if (wr_data) arm_tx_buffer_empty <= 1'b0;
            if (tx_idle && tx_buffer_empty && !brk_pending && !pre_pending && !break_queue)
                tc <= 1'b1;
            else if (!tx_idle || tx_load) tc <= 1'b0;
            if (arm_tc && (wr_data || te_rise || sbk_rise)) begin
                tc <= 1'b0;
                arm_tc <= 1'b0;
            end
            if (rx_store) rx_buffer_full <= 1'b1;
            else if (rd_data && arm_rx_buffer_full) rx_buffer_full <= 1'b0;
            if (rd_data) arm_rx_buffer_full <= 1'b0;
            if (sbk_fall || (break_queue && tx_fin)) brk_pending <= 1'b1;
            else if (tick && tx_idle && brk_pending) brk_pending <= 1'b0;
            if (te_rise) pre_pending <= 1'b1;
            else if (tick && tx_idle && pre_pending && !brk_pending && te)
                pre_pending <= 1'b0;
        end
    end

    // ****************************************
    // bit clock and transmitter
    // ****************************************
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            baud_cnt <= 16'h0000;
            tick <= 1'b0;
        end else begin
            tick <= baud_cnt == 16'h0000;
            baud_cnt <= baud_cnt == 16'h0000 ? BAUD_DIV - 16'h0001
                : baud_cnt - 16'h0001;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            tx_state <= ascf_pkg::ASCF_TX_IDLE;
            tx_sh <= 9'h1ff;
            tx_bits <= 4'h0;
            tx_len <= 4'h0;
            txd <= 1'b1;
        end else if (tick) begin
            case (tx_state)
                ascf_pkg::ASCF_TX_IDLE: begin
                    txd <= 1'b1;
                    tx_bits <= 4'h1;
                    if (brk_pending) begin
                        tx_state <= ascf_pkg::ASCF_TX_BREAK;
                        tx_len <= brk_len;
                        txd <= 1'b0;
                    end else if (pre_pending && te) begin
                        tx_state <= ascf_pkg::ASCF_TX_PREAMBLE;
                        tx_len <= char_len;
                    end else if (tx_load) begin
                        tx_state <= ascf_pkg::ASCF_TX_DATA;
                        tx_len <= char_len;
                        tx_sh <= {1'b1, tx_buf};
                        txd <= 1'b0;
                    end
                end
                ascf_pkg::ASCF_TX_DATA: begin
                    txd <= tx_sh[0];
                    tx_sh <= {1'b1, tx_sh[8:1]};
                    tx_bits <= tx_bits + 4'h1;
                    if (tx_fin) tx_state <= ascf_pkg::ASCF_TX_IDLE;
                end
                ascf_pkg::ASCF_TX_BREAK, ascf_pkg::ASCF_TX_PREAMBLE: begin
                    tx_bits <= tx_bits + 4'h1;
                    if (tx_fin) begin
                        tx_state <= ascf_pkg::ASCF_TX_IDLE;
                        txd <= 1'b1;
                    end
                end
                default: tx_state <= ascf_pkg::ASCF_TX_IDLE;
            endcase
        end
    end
    assign link.port_txd = txd;

    // ****************************************
    // receiver
    // ****************************************
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_prev <= 1'b1;
            rx_state <= ascf_pkg::ASCF_RX_IDLE;
            rx_bits <= 4'h0;
            rx_sh <= 9'h000;
            rx_buf <= 8'h00;
            idle_cnt <= 4'h0;
        end else begin
            rx_s1 <= link.node_txd;
            rx_s2 <= rx_s1;
            if (rx_store) rx_buf <= rx_sh[7:0];
            case (rx_state)
                ascf_pkg::ASCF_RX_IDLE: begin
                    rx_bits <= 4'h0;
                    if (tick) begin
                        rx_prev <= rx_bit;
                        if (rx_bit && idle_cnt != char_len)
                            idle_cnt <= idle_cnt + 4'h1;
                    end
                    if (tick && rx_active && rx_prev && !rx_bit) begin
                        rx_state <= ascf_pkg::ASCF_RX_SHIFT;
                        idle_cnt <= 4'h0;
                    end
                end
                ascf_pkg::ASCF_RX_SHIFT: begin
                    if (rx_sample) begin
                        rx_sh <= {rx_bit, rx_sh[8:1]};
                        rx_bits <= rx_bits + 4'h1;
                        if (rx_bits == (nine ? 4'h9 : 4'h8))
                            rx_state <= ascf_pkg::ASCF_RX_DONE;
                    end
                end
                ascf_pkg::ASCF_RX_DONE: begin
                    rx_state <= ascf_pkg::ASCF_RX_IDLE;
                    rx_prev <= 1'b0;
                end
                default: rx_state <= ascf_pkg::ASCF_RX_IDLE;
            endcase
        end
    end
endmodule : ascf_port

/* File: design/ascf_node.sv */
// remote serial node: sends a byte on request, reports received bytes
`timescale 1ns/1ns
`include "ascf_params.svh"
module ascf_node #(
    parameter logic [15:0] BAUD_DIV = `ASCF_BAUD_DIV
) (
    // system
    input wire logic CLK_SYS,
    input wire logic RST,
    // user side
    input wire logic [7:0] SEND_DATA,
    input wire logic SEND,
    output logic BUSY,
    output logic [7:0] RECV_DATA,
    output logic RECV_VALID,
    // link
    ascf_link_if.node_end link
);
    logic [15:0] cnt;
    logic [9:0] sh;
    logic [3:0] left;
    logic out;
    logic s1, s2;
    logic [3:0] rbits;
    logic [7:0] rsh;
    logic rbusy;
    wire tick = cnt == 16'h0000;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cnt <= 16'h0000;
            sh <= 10'h3ff;
            left <= 4'h0;
            out <= 1'b1;
            BUSY <= 1'b0;
        end else begin
            cnt <= tick ? BAUD_DIV - 16'h0001 : cnt - 16'h0001;
            if (SEND && !BUSY) begin
                sh <= {1'b1, SEND_DATA, 1'b0};
                left <= 4'ha;
                BUSY <= 1'b1;
            end else if (tick && left != 4'h0) begin
                out <= sh[0];
                sh <= {1'b1, sh[9:1]};
                left <= left - 4'h1;
            end else if (tick && BUSY) begin
                BUSY <= 1'b0;
            end
        end
    end
    assign link.node_txd = out;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            rbits <= 4'h0;
            rsh <= 8'h00;
            rbusy <= 1'b0;
            RECV_DATA <= 8'h00;
            RECV_VALID <= 1'b0;
        end else begin
            s1 <= link.port_txd;
            s2 <= s1;
            RECV_VALID <= 1'b0;
            if (!rbusy) begin
                if (tick && !s2) begin
                    rbusy <= 1'b1;
                    rbits <= 4'h0;
                end
            end else if (tick) begin
                // one sample per bit tick; the ninth is the stop bit
                rbits <= rbits + 4'h1;
                rsh <= {s2, rsh[7:1]};
                if (rbits == 4'h8) begin
                    rbusy <= 1'b0;
                    RECV_DATA <= rsh;
                    RECV_VALID <= 1'b1;
                end
            end
        end
    end
endmodule : ascf_node

/* File: test/ascf_link_chk.sv */
// concurrent checks on the register port and the serial link
`timescale 1ns/1ns
`include "ascf_params.svh"
module ascf_link_chk #(
    parameter logic [15:0] BAUD_DIV = 16'h0004
) (
    // system
    input wire logic CLK_SYS,
    input wire logic RST,
    // register port
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic IRQ,
    input wire logic RX_PIN_RELEASED,
    // link
    input wire logic port_txd,
    input wire logic node_txd
);
    localparam int B1 = int'(BAUD_DIV) - 1;
    logic [7:0] c1, c2, quiet;
    logic [15:0] low_cnt, off_cnt;
    logic rd_stat;
    wire c2_wr = WR && ADDR == `ASCF_ADDR_CTRL2;
    wire c1_wr = WR && ADDR == `ASCF_ADDR_CTRL1;
    wire [7:0] next_c2 = c2_wr ? WDATA : c2;
    wire [7:0] next_c1 = c1_wr ? WDATA : c1;
    wire [7:0] next_quiet = (c2_wr || c1_wr) ? 8'h00 :
        (quiet == 8'hff ? quiet : quiet + 8'h01);
    wire [15:0] next_low = port_txd ? 16'h0000 : low_cnt + 16'h0001;
    wire [15:0] next_off = c2[`ASCF_C2_TE] ? 16'h0000 : off_cnt + 16'h0001;
    wire [15:0] brk_len = (c1[`ASCF_C1_LONG_BREAK_SELECT] ? 16'h000d : 16'h000a) * BAUD_DIV;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            c1 <= `ASCF_C1_RESET;
            c2 <= `ASCF_C2_RESET;
            quiet <= 8'h00;
            low_cnt <= 16'h0000;
            off_cnt <= 16'h0000;
            rd_stat <= 1'b0;
        end else begin
            c1 <= next_c1;
            c2 <= next_c2;
            quiet <= next_quiet;
            low_cnt <= next_low;
            off_cnt <= next_off;
            rd_stat <= RD && ADDR == `ASCF_ADDR_STATUS;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    release_track_a: assert property (
        quiet > 8'h03 |-> RX_PIN_RELEASED ==
        (!c2[`ASCF_C2_RE] || c1[`ASCF_C1_LOOP]))
        else $error("receive pin release wrong");
    irq_flags_a: assert property (
        rd_stat && quiet > 8'h03 && |(RDATA[7:5] & c2[7:5]) |-> IRQ)
        else $error("enabled flag without interrupt");
    rdata_idle_a: assert property (
        !RD |=> RDATA == 8'h00)
        else $error("read data outside a read");
    rst_state_a: assert property (
        $fell(RST) |-> port_txd && RX_PIN_RELEASED && !IRQ)
        else $error("state after reset wrong");
    low_bit_a: assert property (
        $fell(port_txd) |-> ##B1 !port_txd)
        else $error("low bit shorter than a bit time");
    break_len_a: assert property (
        $rose(port_txd) && low_cnt > 9 * BAUD_DIV |->
        low_cnt % brk_len == 16'h0000)
        else $error("break length wrong");
    tc_active_a: assert property (
        rd_stat && !$past(port_txd) |-> !RDATA[`ASCF_S1_TC])
        else $error("complete flag set while sending");
    tx_off_a: assert property (
        off_cnt > 15 * BAUD_DIV |-> port_txd)
        else $error("line low with transmitter off");
    cover property ($rose(port_txd) && low_cnt > 9 * BAUD_DIV);
    cover property (rd_stat && RDATA[`ASCF_S1_RX_BUFFER_FULL]);
    cover property (IRQ && c2[`ASCF_C2_RIE]);
endmodule : ascf_link_chk

/* File: test/uart_control_status_flags_tb_top.sv */
// self-checking bench: port and node joined by the serial link
`timescale 1ns/1ns
`include "ascf_params.svh"
module uart_control_status_flags_tb_top;
    localparam logic [15:0] DIV = 16'h0004;
    localparam logic [2:0] ST = `ASCF_ADDR_STATUS;
    localparam logic [2:0] C2 = `ASCF_ADDR_CTRL2;
    localparam logic [2:0] C1 = `ASCF_ADDR_CTRL1;
    localparam logic [2:0] DT = `ASCF_ADDR_DATA;
    localparam logic [2:0] EV = `ASCF_ADDR_IRQ_STAT;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata, recv_data, send_data = 8'h00, d;
    logic irq, released, busy, recv_valid;
    logic send = 1'b0;
    int bad_count = 0;
    int compares = 0;
    ascf_link_if link ();
    always #10 clk_sys = ~clk_sys;
    ascf_port #(.BAUD_DIV(DIV)) u_ascf_port (.CLK_SYS(clk_sys), .RST(rst),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .IRQ(irq), .RX_PIN_RELEASED(released), .link(link));
    ascf_node #(.BAUD_DIV(DIV)) u_ascf_node (.CLK_SYS(clk_sys), .RST(rst),
        .SEND_DATA(send_data), .SEND(send), .BUSY(busy),
        .RECV_DATA(recv_data), .RECV_VALID(recv_valid), .link(link));
    ascf_link_chk #(.BAUD_DIV(DIV)) u_ascf_link_chk (.CLK_SYS(clk_sys),
        .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .IRQ(irq), .RX_PIN_RELEASED(released),
        .port_txd(link.port_txd), .node_txd(link.node_txd));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task automatic exp_reg(input string n, input logic [2:0] a,
        input logic [7:0] m, input logic [7:0] e);
        rd_reg(a, d);
        chk(n, e, d & m);
    endtask : exp_reg
    task automatic pins(input logic e_rel, input logic e_irq);
        repeat (3) @(posedge clk_sys);
        #1 chk("released", {7'h00, e_rel}, {7'h00, released});
        chk("irq", {7'h00, e_irq}, {7'h00, irq});
    endtask : pins
    task automatic node_send(input logic [7:0] v);
        @(posedge clk_sys);
        send_data <= v;
        send <= 1'b1;
        @(posedge clk_sys);
        send <= 1'b0;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys);
            #1;
            if (busy === 1'b0) break;
        end
        repeat (4) @(posedge clk_sys);
    endtask : node_send
    task automatic wait_tc();
        for (int i = 0; i < 60; i++) begin
            rd_reg(ST, d);
            if (d[`ASCF_S1_TC] === 1'b1) break;
        end
        chk("tc_back", 8'h40, d & 8'h40);
    endtask : wait_tc
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    initial begin : watchdog
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        $display("mismatch watchdog expected done seen timeout");
        close_out();
    end
    initial begin : main
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        exp_reg("status", ST, 8'he0, 8'hc0);
        wr_reg(ST, 8'h00);
        exp_reg("status_ro", ST, 8'he0, 8'hc0);
        pins(1'b1, 1'b0);
        wr_reg(C2, 8'h0c);
        pins(1'b0, 1'b0);
        wr_reg(C1, 8'h01);
        pins(1'b1, 1'b0);
        wr_reg(C1, 8'h00);
        $display("test pins done");
        wait_tc();
        exp_reg("arm_tx", ST, 8'hc0, 8'hc0);
        wr_reg(DT, 8'ha5);
        repeat (8) @(posedge clk_sys);
        exp_reg("tc_busy", ST, 8'h40, 8'h00);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            #1;
            if (recv_valid === 1'b1) break;
        end
        chk("tx_data", 8'ha5, recv_data);
        wait_tc();
        exp_reg("tx_buffer_empty_back", ST, 8'h80, 8'h80);
        $display("test transmit done");
        for (int lb = 0; lb < 2; lb++) begin
            wr_reg(C1, lb[0] ? 8'h04 : 8'h00);
            exp_reg("arm_brk", ST, 8'h40, 8'h40);
            wr_reg(C2, 8'h0d);
            wr_reg(C2, 8'h0c);
            repeat (8) @(posedge clk_sys);
            exp_reg("tc_break", ST, 8'h40, 8'h00);
            wait_tc();
        end
        wr_reg(C1, 8'h00);
        exp_reg("arm_pre", ST, 8'h40, 8'h40);
        wr_reg(C2, 8'h04);
        wr_reg(C2, 8'h0c);
        repeat (8) @(posedge clk_sys);
        exp_reg("tc_pre", ST, 8'h40, 8'h00);
        wait_tc();
        $display("test break and preamble done");
        node_send(8'h3c);
        exp_reg("rx_early", DT, 8'hff, 8'h3c);
        exp_reg("rx_buffer_full_kept", ST, 8'h20, 8'h20);
        exp_reg("rx_data", DT, 8'hff, 8'h3c);
        exp_reg("rx_buffer_full_clr", ST, 8'h20, 8'h00);
        exp_reg("rx_event", EV, 8'h04, 8'h04);
        wr_reg(EV, 8'h07);
        exp_reg("ev_clr", EV, 8'h07, 8'h00);
        $display("test receive done");
        wr_reg(C2, 8'h2c);
        pins(1'b0, 1'b0);
        node_send(8'h5a);
        pins(1'b0, 1'b1);
        exp_reg("rx_buffer_full_irq", ST, 8'h20, 8'h20);
        exp_reg("rx_irq_data", DT, 8'hff, 8'h5a);
        wr_reg(EV, 8'h07);
        pins(1'b0, 1'b0);
        wr_reg(C2, 8'h8c);
        pins(1'b0, 1'b1);
        wr_reg(C2, 8'h0c);
        pins(1'b0, 1'b0);
        $display("test interrupt done");
        wr_reg(C1, 8'h02);
        wr_reg(C2, 8'h0e);
        exp_reg("rwu_set", C2, 8'h02, 8'h02);
        node_send(8'h12);
        exp_reg("rwu_hold", C2, 8'h02, 8'h02);
        exp_reg("rx_skip", ST, 8'h20, 8'h00);
        node_send(8'h92);
        exp_reg("rwu_wake", C2, 8'h02, 8'h00);
        exp_reg("rx_addr", ST, 8'h20, 8'h20);
        exp_reg("rx_addr_data", DT, 8'hff, 8'h92);
        wr_reg(C1, 8'h00);
        wr_reg(C2, 8'h0e);
        repeat (60) @(posedge clk_sys);
        exp_reg("rwu_idle", C2, 8'h02, 8'h00);
        $display("test standby done");
        wr_reg(C2, 8'h00);
        repeat (80) @(posedge clk_sys);
        close_out();
    end
endmodule : uart_control_status_flags_tb_top
